/* core/chan_pkg.sv */
package chan_pkg;
  // ==========================================================
  // Channel widths
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int PAR_W = 2;
  // ==========================================================
  // Timing figures in ns and derived cycle counts
  localparam int CLK_NS = 10;
  localparam int CALL_PULSE_NS = 50;
  localparam int WRITE_SETUP_NS = 70;
  localparam int DATA_SETUP_NS = 75;
  localparam int READ_CYCLE_MIN_NS = 380;
  localparam int RESP_TIMEOUT_NS = 2000;
  localparam int CALL_PULSE_CYC = (CALL_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int WRITE_SETUP_CYC = (WRITE_SETUP_NS + DATA_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int READ_CYCLE_CYC = (READ_CYCLE_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESP_TIMEOUT_CYC = RESP_TIMEOUT_NS / CLK_NS;
  localparam int CNT_W = 8;
  // ==========================================================
  // Controller states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CALL,
    ST_WAIT_ACC,
    ST_WAIT_DONE,
    ST_GAP
  } state_t;
endpackage

/* core/chan_source.sv */
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Source drives a 24-bit address for every access.
// - One access-call pulse starts exactly one memory cycle.
// - Direction high means write, low means read.
// - While inhibit is asserted, no access-call is issued or acted on; only idle checks it, a call already set up still goes out.
// - Sixteen data lines, source drives on writes, port on reads.
// - One odd-parity line per byte, made by whoever drives data.
// - Lock keeps two consecutive cycles to one cell uninterrupted.
// - Read cycles spaced no closer than 380 ns, 420 ns typical.
// - No new call until address-accepted pulse ends; zero gap allowed.
// - Direction returns to write promptly after each read.
module chan_source
  import chan_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic CMD_VALID,
  input wire logic CMD_WRITE,
  input wire logic CMD_LOCK,
  input wire logic [chan_pkg::ADDR_W-1:0] CMD_ADDR,
  input wire logic [chan_pkg::DATA_W-1:0] CMD_WDATA,
  input wire logic INHIBIT_IN,
  output logic CMD_READY,
  output logic RSP_VALID,
  output logic [chan_pkg::DATA_W-1:0] RSP_RDATA,
  output logic RSP_PAR_ERR,
  output logic RSP_TIMEOUT,
  output logic [chan_pkg::ADDR_W-1:0] ADDRESS_LINES,
  output logic ACCESS_CALL,
  output logic DIRECTION,
  output logic MEMORY_INHIBIT,
  output logic LOCK_LINE,
  input wire logic [chan_pkg::DATA_W-1:0] CHANNEL_DATA_LINES_IN,
  output logic [chan_pkg::DATA_W-1:0] CHANNEL_DATA_LINES_OUT,
  output logic CHANNEL_DATA_LINES_OE,
  input wire logic [chan_pkg::PAR_W-1:0] BYTE_PARITY_LINES_IN,
  output logic [chan_pkg::PAR_W-1:0] BYTE_PARITY_LINES_OUT,
  output logic BYTE_PARITY_LINES_OE,
  input wire logic ADDRESS_ACCEPTED,
  input wire logic DATA_DONE
);
  import chan_pkg::*;

  // ==========================================================
  // Helpers
  // Odd parity per byte: bit set when byte has an even count of ones
  function automatic logic [PAR_W-1:0] odd_par(input logic [DATA_W-1:0] d);
    odd_par = {~^d[15:8], ~^d[7:0]};
  endfunction

  // Three-stage capture; a change counts when stages two and three agree
  function automatic logic settle(input logic s2, input logic s3, input logic old);
    settle = (s2 == s3) ? s3 : old;
  endfunction

  typedef struct packed {
    state_t state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] gap;
    logic [8:0] tmo;
    logic [2:0] acc_sync;
    logic [2:0] done_sync;
    logic [2:0] inh_sync;
    logic acc_f;
    logic done_f;
    logic inh_f;
    logic acc_seen;
    logic lock_second;
    logic was_read;
    logic [ADDR_W-1:0] addr;
    logic call;
    logic dir;
    logic lock;
    logic [DATA_W-1:0] wdata;
    logic data_oe;
    logic ready;
    logic rsp_valid;
    logic [DATA_W-1:0] rdata;
    logic par_err;
    logic timeout;
  } regs_t;

  regs_t r;
  regs_t next_r;

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    next_r = r;
    // Pin synchronisers; stage one is read only by stage two
    next_r.acc_sync = {r.acc_sync[1:0], ADDRESS_ACCEPTED};
    next_r.done_sync = {r.done_sync[1:0], DATA_DONE};
    next_r.inh_sync = {r.inh_sync[1:0], INHIBIT_IN};
    next_r.acc_f = settle(r.acc_sync[1], r.acc_sync[2], r.acc_f);
    next_r.done_f = settle(r.done_sync[1], r.done_sync[2], r.done_f);
    next_r.inh_f = settle(r.inh_sync[1], r.inh_sync[2], r.inh_f);
    next_r.rsp_valid = 1'b0;
    if (r.gap != '0)
      next_r.gap = r.gap - 1'b1;
    case (r.state)
      ST_IDLE:
      begin
        next_r.dir = 1'b1; // Park on write so port drivers stay off
        next_r.ready = !r.inh_f && r.gap == '0 && !r.acc_f;
        if (CMD_VALID && r.ready && !r.inh_f && !r.acc_f)
        begin
          next_r.addr = CMD_ADDR;
          next_r.dir = CMD_WRITE;
          next_r.lock = CMD_LOCK || r.lock_second;
          next_r.lock_second = CMD_LOCK && !r.lock_second;
          next_r.wdata = CMD_WDATA;
          next_r.data_oe = CMD_WRITE;
          next_r.was_read = !CMD_WRITE;
          next_r.ready = 1'b0;
          next_r.acc_seen = 1'b0;
          next_r.tmo = '0;
          // Writes hold the call back until data has had its set-up time
          next_r.cnt = CMD_WRITE ? CNT_W'(WRITE_SETUP_CYC) : '0;
          next_r.state = ST_CALL;
        end
      end
      ST_CALL:
      begin
        if (r.cnt != '0)
          next_r.cnt = r.cnt - 1'b1;
        else if (!r.call)
        begin
          next_r.call = 1'b1; // One pulse per memory cycle
          next_r.cnt = CNT_W'(CALL_PULSE_CYC);
        end
        else
        begin
          next_r.call = 1'b0;
          next_r.state = ST_WAIT_ACC;
        end
      end
      ST_WAIT_ACC:
      begin
        next_r.tmo = r.tmo + 1'b1;
        if (r.acc_f)
          next_r.acc_seen = 1'b1;
        if (r.done_f)
        begin
          // Read data already valid at data-done start
          next_r.rdata = CHANNEL_DATA_LINES_IN;
          next_r.par_err = r.was_read && (odd_par(CHANNEL_DATA_LINES_IN) != BYTE_PARITY_LINES_IN);
          next_r.state = ST_WAIT_DONE;
        end
        else if (r.tmo == 9'(RESP_TIMEOUT_CYC))
        begin
          // Stretched answers are fine, a dead port is not
          next_r.timeout = 1'b1;
          next_r.state = ST_WAIT_DONE;
        end
      end
      ST_WAIT_DONE:
      begin
        // Wait for both strobes to drop before releasing the channel
        if (!r.done_f && !r.acc_f)
        begin
          next_r.rsp_valid = 1'b1;
          next_r.data_oe = 1'b0;
          next_r.dir = 1'b1;
          if (!r.lock_second)
            next_r.lock = 1'b0;
          next_r.gap = r.was_read ? CNT_W'(READ_CYCLE_CYC) - CNT_W'(r.tmo) : '0;
          if (r.tmo >= 9'(READ_CYCLE_CYC))
            next_r.gap = '0;
          next_r.state = ST_GAP;
        end
      end
      ST_GAP:
      begin
        next_r.timeout = 1'b0;
        next_r.par_err = 1'b0;
        next_r.state = ST_IDLE;
      end
      default:
        next_r.state = ST_IDLE;
    endcase
  end

  // ==========================================================
  // State register
  always_ff @(posedge CORE_CLK)
  begin
    if (!RESET_N)
    begin
      r <= '0;
      r.state <= ST_IDLE;
      r.dir <= 1'b1;
      r.inh_f <= 1'b1; // Treat channel as inhibited until the pin settles
      r.inh_sync <= 3'h7;
    end
    else
      r <= next_r;
  end

  // ==========================================================
  // Outputs straight from flip-flops, except parity out, decoded from the write-data register
  assign CMD_READY = r.ready;
  assign RSP_VALID = r.rsp_valid;
  assign RSP_RDATA = r.rdata;
  assign RSP_PAR_ERR = r.par_err;
  assign RSP_TIMEOUT = r.timeout;
  assign ADDRESS_LINES = r.addr;
  assign ACCESS_CALL = r.call;
  assign DIRECTION = r.dir;
  assign MEMORY_INHIBIT = r.inh_f;
  assign LOCK_LINE = r.lock;
  assign CHANNEL_DATA_LINES_OUT = r.wdata;
  assign CHANNEL_DATA_LINES_OE = r.data_oe;
  assign BYTE_PARITY_LINES_OUT = odd_par(r.wdata);
  assign BYTE_PARITY_LINES_OE = r.data_oe;

  // ==========================================================
  // Checks
  sequence call_rise_s;
    !r.call ##1 r.call;
  endsequence

  // Response strobe is a single cycle wide
  sequence rsp_pulse_s;
    r.rsp_valid ##1 !r.rsp_valid;
  endsequence

  // ==========================================================
  // Check helpers
  // Cycles since the last read call rose; a long repeat would be costly to unroll
  logic [CNT_W-1:0] since_read;

  // Counter saturates so a long idle spell never wraps back into range
  always_ff @(posedge CORE_CLK)
  begin
    if (!RESET_N)
      since_read <= '0;
    else if ($rose(r.call) && !r.dir)
      since_read <= CNT_W'(1);
    else if (since_read != '0 && since_read != '1)
      since_read <= since_read + 1'b1;
  end

  // A response is reported once, never twice for one memory cycle
  rsp_once_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    r.rsp_valid |-> rsp_pulse_s)
    else $error("response strobe longer than one cycle");

  // Ready must stay low while a cycle is in flight
  ready_busy_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    r.state != ST_IDLE |-> !r.ready)
    else $error("ready raised while busy");

  // Reads leave the data lines to the port
  read_release_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    r.state == ST_CALL && !r.dir |-> !r.data_oe)
    else $error("source drives data on a read");

  // Address stands through the whole call pulse
  call_addr_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    r.call && $past(r.call) |-> $stable(r.addr))
    else $error("address changed during call");

  no_call_inhib_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    r.inh_f && r.state == ST_IDLE |=> !(r.state == ST_CALL))
    else $error("call started while inhibited");
  call_width_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    call_rise_s |-> r.call [*6] ##1 !r.call)
    else $error("access call width wrong");
  addr_stable_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    r.state == ST_WAIT_ACC && !r.acc_seen |=> $stable(r.addr) && $stable(r.dir))
    else $error("address moved before acceptance");
  write_drive_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    r.call |-> (r.data_oe == r.dir))
    else $error("data drive does not match direction");
  parity_out_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    r.data_oe |-> ^{BYTE_PARITY_LINES_OUT[0], r.wdata[7:0]} && ^{BYTE_PARITY_LINES_OUT[1], r.wdata[15:8]})
    else $error("outgoing parity not odd");
  dir_park_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    r.rsp_valid |-> r.dir && !r.data_oe)
    else $error("direction not parked on write");
  no_call_acc_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    r.state == ST_IDLE && r.acc_f |=> r.state != ST_CALL)
    else $error("call issued during address accepted");
  read_gap_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    $rose(r.call) && since_read != '0 |-> since_read >= CNT_W'(READ_CYCLE_CYC))
    else $error("read cycles too close");
  lock_pair_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    r.lock_second && r.state == ST_GAP |-> r.lock)
    else $error("lock dropped between locked pair");
endmodule
`default_nettype wire

/* dv/port_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========
// Memory port stand-in, bank idle or busy
module port_model
  import chan_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic [chan_pkg::ADDR_W-1:0] ADDRESS_LINES,
  input wire logic ACCESS_CALL,
  input wire logic DIRECTION,
  input wire logic MEMORY_INHIBIT,
  input wire logic [chan_pkg::DATA_W-1:0] CHANNEL_DATA_LINES_OUT,
  input wire logic CHANNEL_DATA_LINES_OE,
  input wire logic [chan_pkg::PAR_W-1:0] BYTE_PARITY_LINES_OUT,
  input wire logic slow,
  input wire logic bad_par,
  input wire logic mute,
  output logic [chan_pkg::DATA_W-1:0] CHANNEL_DATA_LINES_IN,
  output logic [chan_pkg::PAR_W-1:0] BYTE_PARITY_LINES_IN,
  output logic ADDRESS_ACCEPTED = 1'b0,
  output logic DATA_DONE = 1'b0
);
  logic [17:0] mem [16];
  logic [17:0] rd = 18'h0;
  logic drv = 1'b0;
  logic prev = 1'b0;
  // Released lines show the inverse value, so a stale sample is caught
  assign {BYTE_PARITY_LINES_IN, CHANNEL_DATA_LINES_IN} = CHANNEL_DATA_LINES_OE ?
    {BYTE_PARITY_LINES_OUT, CHANNEL_DATA_LINES_OUT} : (drv ? rd : ~rd);
  // Edge finder for the call strobe
  always @(posedge CORE_CLK) prev <= ACCESS_CALL;
  // One cycle per call; single requester, so a locked pair is never split
  always @(posedge CORE_CLK)
  begin
    if (DIRECTION)
      drv <= 1'b0;
    if (ACCESS_CALL && !prev && !MEMORY_INHIBIT && !mute)
    begin
      repeat (slow ? 12 : 3) @(posedge CORE_CLK);
      ADDRESS_ACCEPTED <= 1'b1;
      repeat (6) @(posedge CORE_CLK);
      ADDRESS_ACCEPTED <= 1'b0;
      repeat (4) @(posedge CORE_CLK);
      // Stored parity comes back on reads, so bad write parity shows later
      if (DIRECTION)
        mem[ADDRESS_LINES[3:0]] <= {BYTE_PARITY_LINES_IN, CHANNEL_DATA_LINES_IN};
      else
      begin
        rd <= mem[ADDRESS_LINES[3:0]] ^ {bad_par, 17'h0};
        drv <= 1'b1;
        @(posedge CORE_CLK);
      end
      DATA_DONE <= 1'b1;
      repeat (7) @(posedge CORE_CLK);
      DATA_DONE <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* dv/memory_channel_port_link_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module memory_channel_port_link_bench;
  import chan_pkg::*;
  logic CORE_CLK = 1'b0, RESET_N = 1'b0, CMD_VALID = 1'b0, CMD_WRITE = 1'b0;
  logic CMD_LOCK = 1'b0, INHIBIT_IN = 1'b0, slow = 1'b0, bad_par = 1'b0, mute = 1'b0;
  logic [23:0] CMD_ADDR = 24'h0, ADDRESS_LINES;
  logic [15:0] CMD_WDATA = 16'h0, RSP_RDATA, CHANNEL_DATA_LINES_IN, CHANNEL_DATA_LINES_OUT;
  logic [1:0] BYTE_PARITY_LINES_IN, BYTE_PARITY_LINES_OUT;
  logic CMD_READY, RSP_VALID, RSP_PAR_ERR, RSP_TIMEOUT, ACCESS_CALL, DIRECTION, LOCK_LINE;
  logic MEMORY_INHIBIT, ADDRESS_ACCEPTED, DATA_DONE, CHANNEL_DATA_LINES_OE, BYTE_PARITY_LINES_OE;
  logic ac_q = 1'b0;
  int miscompares = 0, n_checks = 0, cyc = 0, last = 0, gap = 0;
  chan_source dut (.*);
  port_model pm (.*);
  always #5 CORE_CLK = ~CORE_CLK;
  // ==========
  // Call-to-call spacing in cycles
  always @(posedge CORE_CLK)
  begin
    cyc <= cyc + 1;
    ac_q <= ACCESS_CALL;
    if (ACCESS_CALL && !ac_q)
    begin
      gap <= cyc - last;
      last <= cyc;
    end
  end
  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1)
    begin
      miscompares++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  // One request held until taken, then wait for its answer
  task automatic go(input logic w, l, input logic [23:0] a, input logic [15:0] d);
    @(posedge CORE_CLK);
    #1 {CMD_VALID, CMD_WRITE, CMD_LOCK, CMD_ADDR, CMD_WDATA} = {1'b1, w, l, a, d};
    repeat (300) begin @(posedge CORE_CLK); if (CMD_READY === 1'b1) break; end
    #1 CMD_VALID = 1'b0;
    repeat (400) begin @(posedge CORE_CLK); #1; if (RSP_VALID === 1'b1) break; end
    chk(RSP_VALID === 1'b1, "no response");
  endtask
  task automatic t_rw;
    go(1, 0, 24'h000005, 16'hA5C3);
    chk(RSP_TIMEOUT === 1'b0, "write timed out");
    go(0, 0, 24'h000005, 16'h0);
    chk(RSP_RDATA === 16'hA5C3 && RSP_PAR_ERR === 1'b0, "read back");
    repeat (2) @(posedge CORE_CLK);
    chk(DIRECTION === 1'b1, "direction not parked");
  endtask
  task automatic t_gap;
    go(0, 0, 24'h000005, 16'h0);
    go(0, 0, 24'h000005, 16'h0);
    chk(gap >= 38, "reads too close");
  endtask
  task automatic t_par;
    bad_par = 1'b1;
    go(0, 0, 24'h000005, 16'h0);
    chk(RSP_PAR_ERR === 1'b1, "parity error missed");
    bad_par = 1'b0;
  endtask
  task automatic t_slow;
    slow = 1'b1;
    go(1, 0, 24'h000009, 16'h0F0F);
    go(0, 0, 24'h000009, 16'h0);
    chk(RSP_RDATA === 16'h0F0F && RSP_TIMEOUT === 1'b0, "busy bank");
    slow = 1'b0;
  endtask
  // Requests held off while inhibited, no call comes out
  task automatic t_inh;
    logic hit;
    hit = 1'b0;
    #1 INHIBIT_IN = 1'b1;
    repeat (8) @(posedge CORE_CLK);
    #1 CMD_VALID = 1'b1;
    repeat (30) begin @(posedge CORE_CLK); hit |= ACCESS_CALL | CMD_READY; end
    #1 CMD_VALID = 1'b0;
    chk(hit === 1'b0 && MEMORY_INHIBIT === 1'b1, "call while inhibited");
    INHIBIT_IN = 1'b0;
    repeat (8) @(posedge CORE_CLK);
  endtask
  task automatic t_lock;
    go(1, 1, 24'h000003, 16'h1234);
    chk(LOCK_LINE === 1'b1, "lock dropped mid pair");
    go(1, 0, 24'h000003, 16'h4321);
    repeat (2) @(posedge CORE_CLK);
    chk(LOCK_LINE === 1'b0, "lock stuck");
  endtask
  task automatic t_to;
    mute = 1'b1;
    go(0, 0, 24'h000005, 16'h0);
    chk(RSP_TIMEOUT === 1'b1, "no timeout");
    mute = 1'b0;
  endtask
  task automatic end_sim;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Watchdog at 20000 cycles, far beyond the thousand or so cycles needed
  initial
  begin
    #200000;
    miscompares++;
    end_sim();
  end
  initial
  begin
    repeat (4) @(posedge CORE_CLK);
    chk(DIRECTION === 1'b1 && ACCESS_CALL === 1'b0, "reset values");
    #1 RESET_N = 1'b1;
    repeat (10) @(posedge CORE_CLK);
    t_rw();
    t_gap();
    t_par();
    t_slow();
    t_inh();
    t_lock();
    t_to();
    end_sim();
  end
endmodule
`default_nettype wire
